// ---- rtl/tsb_axil_slave.sv ----
// AXI4-Lite slave front end for byte registers, one per word.
// Assumes the owner decodes index, returns read data and a hit flag.
`timescale 1ns/1ps
module tsb_axil_slave import tsb_pkg::*; #(
    parameter int ADDR_W = 12
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic [1:0]             s_axi_bresp,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   wr_en,
    output logic [7:0]             wr_idx,
    output logic [7:0]             wr_data,
    input  wire logic              wr_hit,
    output logic [7:0]             rd_idx,
    input  wire logic [7:0]        rd_data,
    input  wire logic              rd_hit
);
    logic       aw_full_reg;
    logic       w_full_reg;
    logic [7:0] aw_idx_reg;
    logic [7:0] w_data_reg;
    logic       w_lane_reg;

    // Address and data are held until both have arrived
    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready  = !w_full_reg;
    assign wr_en   = aw_full_reg && w_full_reg && !s_axi_bvalid && w_lane_reg && wr_hit;
    assign wr_idx  = aw_idx_reg;
    assign wr_data = w_data_reg;

    // Write channel capture and response
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            aw_idx_reg   <= 8'h00;
            w_data_reg   <= 8'h00;
            w_lane_reg   <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                aw_idx_reg  <= s_axi_awaddr[9:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata[7:0];
                w_lane_reg <= s_axi_wstrb[0];
            end
            if (aw_full_reg && w_full_reg && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                aw_full_reg  <= 1'b0;
                w_full_reg   <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel: data captured at the address handshake
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_idx        = s_axi_araddr[9:2];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_hit ? rd_data : 8'h00};
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ---- rtl/tsb_core.sv ----
// Transmit symbol shaper: register file, burst and pattern sequencer.
// Assumes symbol codes arrive on a valid/ready stream on clk.
`timescale 1ns/1ps
module tsb_core import tsb_pkg::*; #(
    parameter int ADDR_W = 12
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic [1:0]             s_axi_bresp,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    input  wire logic              sym_valid,
    output logic                   sym_ready,
    input  wire logic [1:0]        sym_code,
    output logic                   tx_out,
    output logic                   tx_active
);
    typedef enum logic [2:0] {
        TSB_IDLE    = 3'b001,
        TSB_BURST   = 3'b010,
        TSB_PATTERN = 3'b100
    } tsb_state_t;

    tsb_state_t state_reg;
    tsb_state_t state_next;

    logic [15:0] sym0_pat_reg;
    logic [15:0] sym1_pat_reg;
    logic [7:0]  sym2_pat_reg;
    logic [7:0]  sym3_pat_reg;
    logic [7:0]  len10_reg;
    logic [7:0]  len32_reg;
    logic [7:0]  burst_ctrl_reg;
    logic [7:0]  mod01_reg;
    logic [7:0]  mod23_reg;
    logic [7:0]  burst_len_reg;
    logic [7:0]  divider_reg;

    logic        wr_en;
    logic [7:0]  wr_idx;
    logic [7:0]  wr_data;
    logic        wr_hit;
    logic [7:0]  rd_idx;
    logic [7:0]  rd_data;
    logic        rd_hit;

    logic [1:0]  code_reg;
    logic [7:0]  div_cnt_reg;
    logic [2:0]  phase_reg;
    logic [7:0]  bit_cnt_reg;
    logic        sc_reg;
    logic        prev_bit_reg;
    logic        eighth_tick;
    logic        bit_end;
    logic        cur_bit;
    logic        shaped;
    logic        pair23;
    tsb_mod_t    cfg;

    // Index is a writable or readable register
    function automatic logic idx_known(input logic [7:0] idx);
        return (idx >= IDX_SYM0_HI && idx <= IDX_MOD23) || idx == IDX_BURST_LEN
            || idx == IDX_DIVIDER || idx == IDX_STATUS;
    endfunction

    // Burst enable, level and alone bits of symbol 0 or 1
    function automatic logic [2:0] burst_bits(input logic [1:0] code,
                                              input logic [7:0] ctrl);
        if (code == 2'd1) begin
            return {ctrl[BC_S1_LEVEL], ctrl[BC_S1_ALONE], ctrl[BC_S1_EN]};
        end
        return {ctrl[BC_S0_LEVEL], ctrl[BC_S0_ALONE], ctrl[BC_S0_EN]};
    endfunction

    // Highest pattern bit index of a symbol
    function automatic logic [7:0] last_bit(input logic [1:0] code);
        unique case (code)
            2'd0:    return {4'h0, len10_reg[3:0]};
            2'd1:    return {4'h0, len10_reg[7:4]};
            2'd2:    return {5'h00, len32_reg[2:0]};
            default: return {5'h00, len32_reg[6:4]};
        endcase
    endfunction

    tsb_axil_slave #(.ADDR_W(ADDR_W)) u_bus (
        .clk           (clk),
        .rst           (rst),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .wr_en         (wr_en),
        .wr_idx        (wr_idx),
        .wr_data       (wr_data),
        .wr_hit        (wr_hit),
        .rd_idx        (rd_idx),
        .rd_data       (rd_data),
        .rd_hit        (rd_hit)
    );

    // Status register is read-only
    assign wr_hit = idx_known(wr_idx) && wr_idx != IDX_STATUS;
    assign rd_hit = idx_known(rd_idx);

    // Register writes, reserved bits masked off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sym0_pat_reg   <= 16'h0000;
            sym1_pat_reg   <= 16'h0000;
            sym2_pat_reg   <= REG_RESET;
            sym3_pat_reg   <= REG_RESET;
            len10_reg      <= REG_RESET;
            len32_reg      <= REG_RESET;
            burst_ctrl_reg <= REG_RESET;
            mod01_reg      <= REG_RESET;
            mod23_reg      <= REG_RESET;
            burst_len_reg  <= REG_RESET;
            divider_reg    <= DIV_RESET;
        end else if (wr_en) begin
            unique case (wr_idx)
                IDX_SYM0_HI:    sym0_pat_reg[15:8] <= wr_data;
                IDX_SYM0_LO:    sym0_pat_reg[7:0]  <= wr_data;
                IDX_SYM1_HI:    sym1_pat_reg[15:8] <= wr_data;
                IDX_SYM1_LO:    sym1_pat_reg[7:0]  <= wr_data;
                IDX_SYM2:       sym2_pat_reg       <= wr_data;
                IDX_SYM3:       sym3_pat_reg       <= wr_data;
                IDX_LEN10:      len10_reg          <= wr_data;
                IDX_LEN32:      len32_reg          <= wr_data & LEN32_MASK;
                IDX_BURST_CTRL: burst_ctrl_reg     <= wr_data & BC_MASK;
                IDX_MOD01:      mod01_reg          <= wr_data & MOD_MASK;
                IDX_MOD23:      mod23_reg          <= wr_data & MOD_MASK;
                IDX_BURST_LEN:  burst_len_reg      <= wr_data;
                IDX_DIVIDER:    divider_reg        <= wr_data;
                default:        ;
            endcase
        end
    end

    // Read multiplexer
    always_comb begin
        unique case (rd_idx)
            IDX_SYM0_HI:    rd_data = sym0_pat_reg[15:8];
            IDX_SYM0_LO:    rd_data = sym0_pat_reg[7:0];
            IDX_SYM1_HI:    rd_data = sym1_pat_reg[15:8];
            IDX_SYM1_LO:    rd_data = sym1_pat_reg[7:0];
            IDX_SYM2:       rd_data = sym2_pat_reg;
            IDX_SYM3:       rd_data = sym3_pat_reg;
            IDX_LEN10:      rd_data = len10_reg;
            IDX_LEN32:      rd_data = len32_reg;
            IDX_BURST_CTRL: rd_data = burst_ctrl_reg;
            IDX_MOD01:      rd_data = mod01_reg;
            IDX_MOD23:      rd_data = mod23_reg;
            IDX_BURST_LEN:  rd_data = burst_len_reg;
            IDX_DIVIDER:    rd_data = divider_reg;
            IDX_STATUS:     rd_data = {6'h00, tx_out, tx_active};
            default:        rd_data = 8'h00;
        endcase
    end

    // Eighth-bit enable pulses while a symbol is sent
    assign eighth_tick = tx_active && div_cnt_reg == divider_reg;
    assign bit_end     = eighth_tick && phase_reg == PH_LAST;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_cnt_reg <= 8'h00;
            phase_reg   <= 3'h0;
            sc_reg      <= 1'b0;
        end else if (!tx_active) begin
            div_cnt_reg <= 8'h00;
            phase_reg   <= 3'h0;
            sc_reg      <= 1'b0;
        end else if (eighth_tick) begin
            div_cnt_reg <= 8'h00;
            phase_reg   <= phase_reg + 3'h1;
            sc_reg      <= !sc_reg;
        end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
        end
    end

    // Current pseudo bit, pattern sent most significant bit first
    always_comb begin
        logic [2:0] bb;
        bb = burst_bits(code_reg, burst_ctrl_reg);
        if (state_reg == TSB_BURST) begin
            cur_bit = bb[2];
        end else begin
            unique case (code_reg)
                2'd0:    cur_bit = sym0_pat_reg[bit_cnt_reg[3:0]];
                2'd1:    cur_bit = sym1_pat_reg[bit_cnt_reg[3:0]];
                2'd2:    cur_bit = sym2_pat_reg[bit_cnt_reg[2:0]];
                default: cur_bit = sym3_pat_reg[bit_cnt_reg[2:0]];
            endcase
        end
    end

    // Next-state decision
    always_comb begin
        logic [2:0] bb;
        logic [2:0] nb;
        bb         = burst_bits(code_reg, burst_ctrl_reg);
        nb         = burst_bits(sym_code, burst_ctrl_reg);
        state_next = state_reg;
        unique case (state_reg)
            TSB_IDLE: begin
                if (sym_valid) begin
                    if (!sym_code[1] && nb[0]) begin
                        state_next = TSB_BURST;
                    end else begin
                        state_next = TSB_PATTERN;
                    end
                end
            end
            TSB_BURST: begin
                if (bit_end && bit_cnt_reg == 8'h00) begin
                    state_next = bb[1] ? TSB_IDLE : TSB_PATTERN;
                end
            end
            TSB_PATTERN: begin
                if (bit_end && bit_cnt_reg == 8'h00) begin
                    state_next = TSB_IDLE;
                end
            end
        endcase
    end

    assign sym_ready = state_reg == TSB_IDLE;
    assign tx_active = state_reg != TSB_IDLE;

    // Sequencer state, symbol code and bit counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg   <= TSB_IDLE;
            code_reg    <= 2'd0;
            bit_cnt_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (sym_valid && sym_ready) begin
                code_reg    <= sym_code;
                bit_cnt_reg <= state_next == TSB_BURST ? burst_len_reg : last_bit(sym_code);
            end else if (bit_end) begin
                if (bit_cnt_reg != 8'h00) begin
                    bit_cnt_reg <= bit_cnt_reg - 8'h01;
                end else if (state_next == TSB_PATTERN) begin
                    bit_cnt_reg <= last_bit(code_reg);
                end
            end
        end
    end

    // Previous bit for Miller coding, kept across symbols
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_bit_reg <= 1'b0;
        end else if (bit_end) begin
            prev_bit_reg <= cur_bit;
        end
    end

    // Pair settings follow the symbol code
    assign pair23 = code_reg[1];
    assign cfg    = tsb_mod_t'(pair23 ? mod23_reg[6:0] : mod01_reg[6:0]);

    tsb_shaper u_shape (
        .bit_val  (cur_bit),
        .prev_bit (prev_bit_reg),
        .phase    (phase_reg),
        .sc       (sc_reg),
        .pair23   (pair23),
        .cfg      (cfg),
        .level    (shaped)
    );

    // Registered modulation output, low when idle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_out <= 1'b0;
        end else begin
            tx_out <= tx_active ? shaped : 1'b0;
        end
    end
endmodule

// ---- rtl/tsb_pkg.sv ----
// Constants, field layouts and types of the transmit symbol shaper.
// Assumes byte-wide registers, each at one aligned 32-bit bus word.
package tsb_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_SYM0_HI    = 8'h4d;
    localparam logic [7:0] IDX_SYM0_LO    = 8'h4e;
    localparam logic [7:0] IDX_SYM1_HI    = 8'h4f;
    localparam logic [7:0] IDX_SYM1_LO    = 8'h50;
    localparam logic [7:0] IDX_SYM2       = 8'h51;
    localparam logic [7:0] IDX_SYM3       = 8'h52;
    localparam logic [7:0] IDX_LEN10      = 8'h53;
    localparam logic [7:0] IDX_LEN32      = 8'h54;
    localparam logic [7:0] IDX_BURST_CTRL = 8'h55;
    localparam logic [7:0] IDX_MOD01      = 8'h56;
    localparam logic [7:0] IDX_MOD23      = 8'h57;
    localparam logic [7:0] IDX_BURST_LEN  = 8'h60;
    localparam logic [7:0] IDX_DIVIDER    = 8'h61;
    localparam logic [7:0] IDX_STATUS     = 8'h62;
    // Burst control fields
    localparam int BC_S1_LEVEL = 6;
    localparam int BC_S1_ALONE = 5;
    localparam int BC_S1_EN    = 4;
    localparam int BC_S0_LEVEL = 2;
    localparam int BC_S0_ALONE = 1;
    localparam int BC_S0_EN    = 0;
    // Writable masks, reserved bits stay zero
    localparam logic [7:0] BC_MASK    = 8'h77;
    localparam logic [7:0] MOD_MASK   = 8'h7f;
    localparam logic [7:0] LEN32_MASK = 8'h77;
    // Envelope and pulse codes
    localparam logic [2:0] ENV_DIRECT   = 3'h0;
    localparam logic [2:0] ENV_MANCH    = 3'h1;
    localparam logic [2:0] ENV_MANCH_SC = 3'h2;
    localparam logic [2:0] ENV_BPSK     = 3'h3;
    localparam logic [2:0] ENV_RZ_LATE  = 3'h4;
    localparam logic [2:0] ENV_RZ_EARLY = 3'h5;
    localparam logic [1:0] PULSE_NONE   = 2'h0;
    localparam logic [1:0] PULSE_START  = 2'h1;
    localparam logic [1:0] PULSE_HALF   = 2'h2;
    localparam logic [1:0] PULSE_Q3     = 2'h3;
    // Eighth-bit phases
    localparam logic [2:0] PH_START = 3'h0;
    localparam logic [2:0] PH_HALF  = 3'h4;
    localparam logic [2:0] PH_Q3    = 3'h6;
    localparam logic [2:0] PH_LAST  = 3'h7;
    // Timing: default bit rate and eighth-bit divider
    localparam int CLK_KHZ       = 200000;
    localparam int BIT_RATE_KHZ  = 106;
    localparam int EIGHTH_CYCLES = CLK_KHZ / (BIT_RATE_KHZ * 8);
    localparam logic [7:0] DIV_RESET = 8'(EIGHTH_CYCLES - 1);
    localparam logic [7:0] REG_RESET = 8'h00;
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Modulation settings of one symbol pair
    typedef struct packed {
        logic       miller;
        logic [1:0] pulse;
        logic       inv;
        logic [2:0] env;
    } tsb_mod_t;
endpackage

// ---- rtl/tsb_shaper.sv ----
// Combines one pseudo bit with envelope, pulse placement and inversion.
// Assumes phase counts eighths of a bit and sc is the subcarrier level.
`timescale 1ns/1ps
module tsb_shaper import tsb_pkg::*; (
    input  wire logic       bit_val,
    input  wire logic       prev_bit,
    input  wire logic [2:0] phase,
    input  wire logic       sc,
    input  wire logic       pair23,
    input  wire tsb_mod_t   cfg,
    output logic            level
);
    logic env_lvl;
    logic pulse_on;
    logic first_half;

    // Envelope, then pulse, then inversion
    always_comb begin
        first_half = (phase < PH_HALF);
        unique case (cfg.env)
            ENV_DIRECT:   env_lvl = bit_val;
            ENV_MANCH:    env_lvl = first_half ? bit_val : !bit_val;
            ENV_MANCH_SC: env_lvl = (first_half ? bit_val : !bit_val) & sc;
            ENV_BPSK:     env_lvl = sc ^ bit_val;
            ENV_RZ_LATE:  env_lvl = bit_val & !first_half;
            ENV_RZ_EARLY: env_lvl = bit_val & (pair23 ? first_half : !first_half);
            default:      env_lvl = 1'b0;
        endcase
        // One-eighth pause where the pulse sits
        unique case (cfg.pulse)
            PULSE_START: pulse_on = (phase == PH_START);
            PULSE_HALF:  pulse_on = (phase == PH_HALF);
            PULSE_Q3:    pulse_on = (phase == PH_Q3);
            default:     pulse_on = 1'b0;
        endcase
        if (cfg.miller) begin
            // One: pause mid-bit; zero after zero: pause at start
            pulse_on = bit_val ? (phase == PH_HALF) : (!prev_bit && phase == PH_START);
            level    = !pulse_on;
        end else if (cfg.pulse != PULSE_NONE) begin
            level = !(pulse_on && env_lvl);
        end else begin
            level = env_lvl;
        end
        level = level ^ cfg.inv;
    end
endmodule

// ---- testbench/tb_tsb_core.sv ----
// Bench: registers over AXI4-Lite, symbols sent, RF level captured.
// Assumes divider 0, so one eighth of a bit per clock.
`timescale 1ns/1ps
module tb_tsb_core import tsb_pkg::*;;
    logic clk, rst, awv, wv, bre, arv, rre, sv, clr;
    logic [11:0] awa, ara;
    logic [31:0] wd, got;
    logic [1:0]  sc, resp, hs;
    wire         awr, w_rdy, bv, arr, rv, sr, txo, txa;
    wire [1:0]   br, rr;
    wire [31:0]  rd, smp;
    wire [15:0]  ns;
    int err_total, checks_done, cyc;
    // Rows: index, value, symbol, samples, last samples
    logic [43:0] rows [27] = '{44'h57_50_2_08_00f7, 44'h57_10_2_08_007f, 44'h57_20_2_08_00f7,
        44'h57_30_2_08_00fd, 44'h57_04_2_08_000f, 44'h57_05_2_08_00f0, 44'h57_06_2_08_0000,
        44'h57_08_2_08_0000, 44'h57_01_2_08_00f0, 44'h57_02_2_08_0050, 44'h57_03_2_08_00aa,
        44'h57_00_2_08_00ff, 44'h56_04_0_08_000f, 44'h56_05_0_08_000f,
        44'h56_08_0_08_0000, 44'h56_50_0_08_00f7, 44'h56_20_0_08_00f7, 44'h56_00_0_08_00ff,
        44'h53_1f_0_80_00ff, 44'h53_1f_1_10_00ff, 44'h54_70_3_40_00ff, 44'h53_00_0_08_00ff,
        44'h55_07_0_08_00ff, 44'h55_01_0_10_00ff, 44'h55_70_1_08_00ff, 44'h55_10_1_10_00ff,
        44'h60_01_1_18_00ff};
    tsb_core DUT (.clk(clk), .rst(rst), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(w_rdy), .s_axi_wdata(wd),
        .s_axi_wstrb(4'h1), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .s_axi_rdata(rd), .s_axi_rresp(rr), .sym_valid(sv),
        .sym_ready(sr), .sym_code(sc), .tx_out(txo), .tx_active(txa));
    tsb_rf_model u_rf (.clk(clk), .clr(clr), .tx_out(txo), .tx_active(txa),
        .samples(smp), .n_samples(ns));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic finish_test;
        $display("mismatches %0d, checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        @(posedge clk);
        awa <= {2'b00, i, 2'b00};
        wd  <= {24'h0, d};
        awv <= 1'b1;
        wv  <= 1'b1;
        bre <= 1'b1;
        hs = 2'b11;
        while (hs != 2'b00) begin
            @(negedge clk);
            hs = hs & ~{awr, w_rdy};
            @(posedge clk);
            if (!hs[1]) awv <= 1'b0;
            if (!hs[0]) wv <= 1'b0;
        end
        do @(negedge clk); while (!bv);
        resp = br;
        @(posedge clk);
        bre <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] i);
        @(posedge clk);
        ara <= {2'b00, i, 2'b00};
        arv <= 1'b1;
        rre <= 1'b1;
        do @(negedge clk); while (!arr);
        @(posedge clk);
        arv <= 1'b0;
        do @(negedge clk); while (!rv);
        got  = rd;
        resp = rr;
        @(posedge clk);
        rre <= 1'b0;
    endtask
    // Send one symbol, then compare what the RF side saw
    task automatic send(input logic [1:0] c, input logic [7:0] n, input logic [15:0] e);
        @(posedge clk);
        clr <= 1'b1;
        sv  <= 1'b1;
        sc  <= c;
        do @(negedge clk); while (!sr);
        @(posedge clk);
        sv  <= 1'b0;
        clr <= 1'b0;
        do @(negedge clk); while (txa);
        @(posedge clk);
        @(negedge clk);
        chk(32'(ns), 32'(n));
        chk(smp, {16'h0, e});
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        {awv, wv, bre, arv, rre, sv, clr} = '0;
        {awa, ara, wd, sc} = '0;
        rst = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            rd_reg(8'(IDX_BURST_CTRL + k));
            chk(got, 32'h0);
        end
        wr(IDX_BURST_CTRL, 8'hff);
        chk(32'(resp), 32'(RESP_OKAY));
        rd_reg(IDX_BURST_CTRL);
        chk(got, 32'h77);
        wr(IDX_MOD01, 8'hff);
        rd_reg(IDX_MOD01);
        chk(got, 32'h7f);
        rd_reg(8'h70);
        chk(32'(resp), 32'(RESP_SLVERR));
        wr(IDX_STATUS, 8'h03);
        chk(32'(resp), 32'(RESP_SLVERR));
        rd_reg(IDX_STATUS);
        chk(got, 32'h0);
        wr(IDX_BURST_CTRL, 8'h00);
        wr(IDX_DIVIDER, 8'h00);
        wr(IDX_SYM0_LO, 8'h01);
        wr(IDX_SYM1_LO, 8'h01);
        wr(IDX_SYM2, 8'h01);
        wr(IDX_SYM3, 8'h81);
        foreach (rows[k]) begin
            wr(rows[k][43:36], rows[k][35:28]);
            send(rows[k][25:24], rows[k][23:16], rows[k][15:0]);
        end
        finish_test();
    end
endmodule

// ---- testbench/tsb_core_asserts.sv ----
// Checker on the shaper ports: symbol framing and bus answers.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module tsb_core_asserts (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        sym_valid,
    input wire logic        sym_ready,
    input wire logic        tx_out,
    input wire logic        tx_active,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // A symbol offered while idle is taken
    sequence s_take;
        sym_valid && sym_ready;
    endsequence
    a_take_starts: assert property (s_take |=> tx_active)
        else $error("symbol taken but not started");
    a_busy_refuse: assert property (tx_active |-> !sym_ready)
        else $error("ready while busy");
    a_bit_length: assert property ($rose(tx_active) |-> tx_active[*8])
        else $error("symbol shorter than one bit");
    a_idle_quiet: assert property (!tx_active && !$past(tx_active) |-> !tx_out)
        else $error("output active while idle");
    a_bresp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    a_rdata_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response not released");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken during response");
endmodule
bind tsb_core tsb_core_asserts u_chk (.clk, .rst, .sym_valid, .sym_ready, .tx_out,
    .tx_active, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// ---- testbench/tsb_rf_model.sv ----
// RF path stand-in: records the shaped level, one sample per cycle.
// Assumes tx_out lags tx_active by one cycle through its output register.
`timescale 1ns/1ps
module tsb_rf_model (
    input  wire logic        clk,
    input  wire logic        clr,
    input  wire logic        tx_out,
    input  wire logic        tx_active,
    output logic [31:0]      samples,
    output logic [15:0]      n_samples
);
    logic act_d;
    // Shift in the level while a symbol is on air
    always_ff @(posedge clk) begin
        act_d <= tx_active;
        if (clr) begin
            samples   <= '0;
            n_samples <= '0;
        end else if (act_d) begin
            samples   <= {samples[30:0], tx_out};
            n_samples <= n_samples + 16'h1;
        end
    end
endmodule
